// file: stv_defs.svh
// constants for the tag/vlan parser and flow lookup
// included by the package user files; no processes here
`ifndef STV_DEFS_SVH
`define STV_DEFS_SVH
`define STV_HDR_LEN     6'h24
`define STV_NFLOW       16
`define STV_NWORD       13
`define STV_FLOW_BASE   12'h100
`define STV_FLOW_SPAN   12'h400
`define STV_REG_PARSE   12'h000
`define STV_REG_VLAN    12'h004
`define STV_REG_REMAP   12'h008
`define STV_REG_TAGTYPE 12'h00C
`define STV_REG_STATUS  12'h010
`define STV_PARSE_RST   32'h0000007E
`define STV_VLAN_RST    32'h00000038
`define STV_REMAP_RST   32'h00FAC688
`define STV_TAGTYPE_RST 32'h88A88100
`define STV_SECTAG_ET   16'h88E5
`define STV_SL_LIMIT    6'h30
`define STV_ET_OFS      6'h0C
`define STV_TAG_LEN     6'h04
`define STV_LBL_OFS     6'h0E
`define STV_ST_TCI      6'h02
`define STV_ST_SL       6'h03
`define STV_ST_PN       6'h04
`define STV_ST_SCI      6'h08
`define STV_PC_BYPASS   0
`define STV_PC_V        1
`define STV_PC_CE       2
`define STV_PC_SC       3
`define STV_PC_SL       4
`define STV_PC_PN       5
`define STV_PC_IGR      6
`define STV_PC_LBL      7
`define STV_VC_UPEN     3
`define STV_VC_QEN      4
`define STV_VC_SEN      5
`define STV_TCI_V       7
`define STV_TCI_ES      6
`define STV_TCI_SC      5
`define STV_TCI_SCB     4
`define STV_TCI_E       3
`define STV_TCI_C       2
`define STV_TPID_LSB    16
`define STV_PCP_LSB     13
`define STV_W_DA0       0
`define STV_W_ADR1      1
`define STV_W_SA1       2
`define STV_W_MASK      3
`define STV_W_MISC      4
`define STV_W_VID       5
`define STV_W_SCI0      6
`define STV_W_SCI1      7
`define STV_W_AN        8
`define STV_W_LBL0      9
`define STV_W_LBL1      10
`define STV_W_LM0       11
`define STV_W_LM1       12
`define STV_M_ET        12
`define STV_M_VC        13
`define STV_M_UP        17
`define STV_M_VID       18
`define STV_M_IUP       19
`define STV_M_IVID      20
`define STV_M_CTL       21
`define STV_M_SCI       22
`define STV_F_ET        0
`define STV_F_VC        16
`define STV_F_UP        20
`define STV_F_CTL       23
`define STV_F_CAT       24
`define STV_F_PRIO      28
`define STV_F_VID       0
`define STV_F_IVID      12
`define STV_F_IUP       24
`define STV_F_EN        31
`define STV_F_AN        0
`define STV_F_ANM       8
`endif

// file: stv_pkg.sv
// types shared by the parser, lookup and carrier interface
// uses no macros and does not include stv_defs.svh
package stv_pkg;
	typedef enum logic [1:0] {CAT_UNTAGGED, CAT_TAGGED, CAT_BAD, CAT_KAY} stv_cat_type;
	typedef enum logic [1:0] {ST_CAPTURE, ST_LOOKUP, ST_HOLD} stv_state_type;
endpackage : stv_pkg

// file: stv_prs_if.sv
// parse results carried from the classifier to each flow matcher
// driven combinationally from held header bytes
`timescale 1ns/1ps
`default_nettype none
interface stv_prs_if;
	import stv_pkg::*;
	stv_cat_type cat;
	logic        ctrl;
	logic [95:0] addr;
	logic [15:0] etype;
	logic [3:0]  vclass;
	logic [2:0]  up;
	logic [2:0]  iup;
	logic [11:0] vid;
	logic [11:0] ivid;
	logic [63:0] sci;
	logic [7:0]  an;
	logic [63:0] label;
	logic        igr;
	logic        lbl_mode;
	modport prod (output cat, ctrl, addr, etype, vclass, up, iup, vid, ivid, sci, an, label, igr, lbl_mode);
	modport cons (input cat, ctrl, addr, etype, vclass, up, iup, vid, ivid, sci, an, label, igr, lbl_mode);
endinterface : stv_prs_if
`default_nettype wire

// file: stv_flow_match.sv
// one association flow compared against the parsed frame
// flow words come from the classifier register array
`timescale 1ns/1ps
`default_nettype none
`include "stv_defs.svh"
module stv_flow_match
	import stv_pkg::*;
(
	stv_prs_if.cons          p,
	input  wire logic [31:0] w [`STV_NWORD],
	output logic             hit,
	output logic [3:0]       prio
);
	logic [95:0] fadr;
	logic [11:0] bmask;
	logic [31:0] m;
	logic [31:0] misc;
	logic [31:0] vw;
	logic [3:0]  cats;
	logic        ok_adr;
	logic        ok_sec;
	logic        ok_lbl;

	always_comb begin
		fadr  = {w[`STV_W_SA1], w[`STV_W_ADR1], w[`STV_W_DA0]};
		m     = w[`STV_W_MASK];
		misc  = w[`STV_W_MISC];
		vw    = w[`STV_W_VID];
		bmask = m[11:0];
		cats  = misc[`STV_F_CAT +: 4];
		ok_adr = 1'b1;
		for (int i = 0; i < 12; i++) begin
			if (bmask[i] && (fadr[i*8 +: 8] != p.addr[i*8 +: 8])) begin
				ok_adr = 1'b0;
			end
		end
		// sci and association number only for tagged ingress frames
		ok_sec = !(p.igr && p.cat == CAT_TAGGED) ||
			((!m[`STV_M_SCI] || {w[`STV_W_SCI1], w[`STV_W_SCI0]} == p.sci) &&
			((w[`STV_W_AN][`STV_F_ANM +: 8] & (w[`STV_W_AN][`STV_F_AN +: 8] ^ p.an)) == 8'h00));
		ok_lbl = !p.lbl_mode ||
			((({w[`STV_W_LM1], w[`STV_W_LM0]}) & ({w[`STV_W_LBL1], w[`STV_W_LBL0]} ^ p.label)) == 64'h0);
		hit = vw[`STV_F_EN] && cats[p.cat] && ok_adr && ok_sec && ok_lbl
			&& (!m[`STV_M_ET] || misc[`STV_F_ET +: 16] == p.etype)
			&& ((m[`STV_M_VC +: 4] & (misc[`STV_F_VC +: 4] ^ p.vclass)) == 4'h0)
			&& (!m[`STV_M_UP] || misc[`STV_F_UP +: 3] == p.up)
			&& (!m[`STV_M_VID] || vw[`STV_F_VID +: 12] == p.vid)
			&& (!m[`STV_M_IUP] || vw[`STV_F_IUP +: 3] == p.iup)
			&& (!m[`STV_M_IVID] || vw[`STV_F_IVID +: 12] == p.ivid)
			&& (!m[`STV_M_CTL] || misc[`STV_F_CTL] == p.ctrl);
		prio = misc[`STV_F_PRIO +: 4];
	end
endmodule : stv_flow_match
`default_nettype wire

// file: stv_vlan_dec.sv
// decodes one four-byte vlan tag candidate
// tag type ethertypes come from configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "stv_defs.svh"
module stv_vlan_dec (
	input  wire logic [31:0] tag,
	input  wire logic [15:0] q_et,
	input  wire logic [15:0] s_et,
	input  wire logic        q_en,
	input  wire logic        s_en,
	output logic             is_q,
	output logic             is_s,
	output logic [2:0]       pcp,
	output logic [11:0]      vid
);
	always_comb begin
		is_q = q_en && (tag[`STV_TPID_LSB +: 16] == q_et);
		is_s = s_en && (tag[`STV_TPID_LSB +: 16] == s_et);
		pcp  = tag[`STV_PCP_LSB +: 3];
		vid  = tag[11:0];
	end
endmodule : stv_vlan_dec
`default_nettype wire

// file: stv_classifier.sv
// frame tag/vlan classification and association flow lookup
// byte stream in from the mac side; result held until consumed
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stv_defs.svh"
// What this block does
// - security tag only right after source address, unless vlan bypass mode
// - ethertype at tag position other than 0x88E5 means untagged
// - security ethertype with C clear and E set means key-agreement, unless V set with its check on
// - bad tag on V, C without E, SC with ES/SCB, SL>=48, PN zero
// - other security-tagged frames are tagged, only category eligible for transforms
// - key-agreement frames only pass straight through, never transformed
// - parse check register selects which tag checks apply
// - recognise Q and S tags after source address, up to two stacked
// - flags: any vlan, first is Q, first is S, two tags
// - outer priority from first tag, else default or when disabled
// - outer vlan id from first tag, undefined without tag
// - inner priority from second tag through remap table
// - inner vlan id from second tag; ethertype after zero to two tags
// - only enabled flows can match
// - highest four-bit priority wins, ties go to lowest index
// - priority field always four bits
// - on miss pick one of eight flows by category and control bit
// - hit bit plus index; miss index from control bit and category
// - four category enables per flow; clear bit blocks that category
// - masked criteria compared only when mask bit set
// - address bytes under twelve byte masks; vlan flags under four masks
// - sci and association byte only for ingress tagged frames, byte bitmasked
// - match parsed ethertype; 64-bit bitmasked label window in header bypass
// - control stage supplies one control bit per frame
module stv_classifier
	import stv_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [7:0]  in_data,
	input  wire logic        in_eop,
	input  wire logic        in_ctrl,
	output logic             res_valid,
	input  wire logic        res_ready,
	output logic             res_hit,
	output logic [3:0]       res_index,
	output logic [1:0]       res_cat,
	output logic             res_ctrl,
	output logic             res_xform_ok,
	output logic [3:0]       res_vclass,
	output logic [2:0]       res_up,
	output logic [11:0]      res_vid,
	output logic [2:0]       res_iup,
	output logic [11:0]      res_ivid,
	output logic [15:0]      res_etype
);
	stv_state_type state_ff;
	logic [5:0]  cnt_ff;
	logic [7:0]  hdr_ff [`STV_HDR_LEN];
	logic        ctrl_ff;
	logic [31:0] pcfg_ff;
	logic [31:0] vcfg_ff;
	logic [31:0] remap_ff;
	logic [31:0] ttype_ff;
	logic [31:0] flow_ff [`STV_NFLOW][`STV_NWORD];
	logic [11:0] awaddr_ff;
	logic        awf_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        wf_ff;
	logic        wr_go;
	logic [11:0] fo_w;
	logic [11:0] fo_r;

	stv_prs_if prs ();

	logic        t1q, t1s, t2q, t2s, v1, v2;
	logic [2:0]  t1pcp, t2pcp;
	logic [11:0] t1vid, t2vid;
	logic [5:0]  eofs;
	logic [5:0]  tpos;
	logic [15:0] st_et;
	logic [7:0]  tci;
	logic [5:0]  sl;
	logic [31:0] pn;
	logic        bad;

	stv_vlan_dec u_tag1 (
		.tag  ({hdr_ff[12], hdr_ff[13], hdr_ff[14], hdr_ff[15]}),
		.q_et (ttype_ff[15:0]),
		.s_et (ttype_ff[31:16]),
		.q_en (vcfg_ff[`STV_VC_QEN]),
		.s_en (vcfg_ff[`STV_VC_SEN]),
		.is_q (t1q),
		.is_s (t1s),
		.pcp  (t1pcp),
		.vid  (t1vid)
	);

	stv_vlan_dec u_tag2 (
		.tag  ({hdr_ff[16], hdr_ff[17], hdr_ff[18], hdr_ff[19]}),
		.q_et (ttype_ff[15:0]),
		.s_et (ttype_ff[31:16]),
		.q_en (vcfg_ff[`STV_VC_QEN]),
		.s_en (vcfg_ff[`STV_VC_SEN]),
		.is_q (t2q),
		.is_s (t2s),
		.pcp  (t2pcp),
		.vid  (t2vid)
	);

	// header parse from the held bytes
	always_comb begin
		v1   = t1q || t1s;
		v2   = v1 && (t2q || t2s);
		eofs = `STV_ET_OFS + (v1 ? `STV_TAG_LEN : 6'h00) + (v2 ? `STV_TAG_LEN : 6'h00);
		tpos = pcfg_ff[`STV_PC_BYPASS] ? eofs : `STV_ET_OFS;
		st_et = {hdr_ff[tpos], hdr_ff[tpos + 6'h01]};
		tci   = hdr_ff[tpos + `STV_ST_TCI];
		sl    = hdr_ff[tpos + `STV_ST_SL][5:0];
		pn    = 32'h0;
		prs.sci = 64'h0;
		prs.addr = 96'h0;
		prs.label = 64'h0;
		for (int k = 0; k < 4; k++) begin
			pn = {pn[23:0], hdr_ff[tpos + `STV_ST_PN + 6'(k)]};
		end
		for (int k = 0; k < 8; k++) begin
			prs.sci   = {prs.sci[55:0], hdr_ff[tpos + `STV_ST_SCI + 6'(k)]};
			prs.label = {prs.label[55:0], hdr_ff[`STV_LBL_OFS + 6'(k)]};
		end
		// sa bytes first so the da lands in the low half
		for (int k = 0; k < 12; k++) begin
			prs.addr = {prs.addr[87:0], hdr_ff[(k + 6) % 12]};
		end
		bad = (pcfg_ff[`STV_PC_CE] && tci[`STV_TCI_C] && !tci[`STV_TCI_E])
			|| (pcfg_ff[`STV_PC_SC] && tci[`STV_TCI_SC] && (tci[`STV_TCI_ES] || tci[`STV_TCI_SCB]))
			|| (pcfg_ff[`STV_PC_SL] && sl >= `STV_SL_LIMIT)
			|| (pcfg_ff[`STV_PC_PN] && pn == 32'h0);
		if (st_et != `STV_SECTAG_ET) begin
			prs.cat = CAT_UNTAGGED;
		end else if (pcfg_ff[`STV_PC_V] && tci[`STV_TCI_V]) begin
			prs.cat = CAT_BAD;
		end else if (!tci[`STV_TCI_C] && tci[`STV_TCI_E]) begin
			prs.cat = CAT_KAY;
		end else if (bad) begin
			prs.cat = CAT_BAD;
		end else begin
			prs.cat = CAT_TAGGED;
		end
		prs.an     = tci;
		prs.ctrl   = ctrl_ff;
		prs.etype  = {hdr_ff[eofs], hdr_ff[eofs + 6'h01]};
		prs.vclass = {v2, t1s, t1q, v1};
		prs.up     = (v1 && vcfg_ff[`STV_VC_UPEN]) ? t1pcp : vcfg_ff[2:0];
		prs.vid    = t1vid;
		prs.iup    = remap_ff[5'(t2pcp) * 5'h03 +: 3];
		prs.ivid   = t2vid;
		prs.igr    = pcfg_ff[`STV_PC_IGR];
		prs.lbl_mode = pcfg_ff[`STV_PC_LBL];
	end

	logic [`STV_NFLOW-1:0] fhit;
	logic [3:0]            fpr [`STV_NFLOW];

	genvar g;
	generate
		for (g = 0; g < `STV_NFLOW; g++) begin : gen_flow
			stv_flow_match u_match (
				.p    (prs.cons),
				.w    (flow_ff[g]),
				.hit  (fhit[g]),
				.prio (fpr[g])
			);
		end
	endgenerate

	logic       best_hit;
	logic [3:0] best_idx;
	logic [3:0] best_pr;

	// strict compare keeps the lowest index on a priority tie
	always_comb begin
		best_hit = 1'b0;
		best_idx = 4'h0;
		best_pr  = 4'h0;
		for (int i = 0; i < `STV_NFLOW; i++) begin
			if (fhit[i] && (!best_hit || fpr[i] > best_pr)) begin
				best_hit = 1'b1;
				best_idx = 4'(i);
				best_pr  = fpr[i];
			end
		end
	end

	// frame sequencing: capture, lookup, hold
	assign in_ready  = (state_ff == ST_CAPTURE);
	assign res_valid = (state_ff == ST_HOLD);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_CAPTURE;
		end else begin
			case (state_ff)
				ST_CAPTURE: begin
					if (in_valid && in_eop) begin
						state_ff <= ST_LOOKUP;
					end
				end
				ST_LOOKUP: state_ff <= ST_HOLD;
				ST_HOLD: begin
					if (res_ready) begin
						state_ff <= ST_CAPTURE;
					end
				end
				default: state_ff <= ST_CAPTURE;
			endcase
		end
	end

	// header bytes held until the result is taken
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff  <= 6'h00;
			ctrl_ff <= 1'b0;
			for (int i = 0; i < `STV_HDR_LEN; i++) begin
				hdr_ff[i] <= 8'h00;
			end
		end else if (state_ff == ST_CAPTURE && in_valid) begin
			if (cnt_ff < `STV_HDR_LEN) begin
				hdr_ff[cnt_ff] <= in_data;
				cnt_ff <= cnt_ff + 6'h01;
			end
			if (in_eop) begin
				ctrl_ff <= in_ctrl;
			end
		end else if (state_ff == ST_HOLD && res_ready) begin
			cnt_ff <= 6'h00;
			for (int i = 0; i < `STV_HDR_LEN; i++) begin
				hdr_ff[i] <= 8'h00;
			end
		end
	end

	// lookup result register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_hit      <= 1'b0;
			res_index    <= 4'h0;
			res_cat      <= 2'h0;
			res_ctrl     <= 1'b0;
			res_xform_ok <= 1'b0;
			res_vclass   <= 4'h0;
			res_up       <= 3'h0;
			res_vid      <= 12'h000;
			res_iup      <= 3'h0;
			res_ivid     <= 12'h000;
			res_etype    <= 16'h0000;
		end else if (state_ff == ST_LOOKUP) begin
			res_hit      <= best_hit;
			res_index    <= best_hit ? best_idx : {1'b0, ctrl_ff, prs.cat};
			res_cat      <= prs.cat;
			res_ctrl     <= ctrl_ff;
			res_xform_ok <= best_hit && prs.cat == CAT_TAGGED;
			res_vclass   <= prs.vclass;
			res_up       <= prs.up;
			res_vid      <= prs.vid;
			res_iup      <= prs.iup;
			res_ivid     <= prs.ivid;
			res_etype    <= prs.etype;
		end
	end

	// axi4-lite write side
	assign s_axi_awready = !awf_ff && !s_axi_bvalid;
	assign s_axi_wready  = !wf_ff && !s_axi_bvalid;
	assign wr_go         = awf_ff && wf_ff;
	assign fo_w          = awaddr_ff - `STV_FLOW_BASE;
	assign fo_r          = s_axi_araddr - `STV_FLOW_BASE;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic flow_hit(input logic [11:0] a, input logic [11:0] fo);
		return a >= `STV_FLOW_BASE && fo < `STV_FLOW_SPAN && 32'(fo[5:2]) < `STV_NWORD;
	endfunction : flow_hit

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awf_ff       <= 1'b0;
			wf_ff        <= 1'b0;
			awaddr_ff    <= 12'h000;
			wdata_ff     <= 32'h0;
			wstrb_ff     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awf_ff    <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wf_ff    <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				awf_ff       <= 1'b0;
				wf_ff        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_ff)
					`STV_REG_PARSE, `STV_REG_VLAN, `STV_REG_REMAP,
					`STV_REG_TAGTYPE, `STV_REG_STATUS: s_axi_bresp <= 2'h0;
					default: s_axi_bresp <= flow_hit(awaddr_ff, fo_w) ? 2'h0 : 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pcfg_ff  <= `STV_PARSE_RST;
			vcfg_ff  <= `STV_VLAN_RST;
			remap_ff <= `STV_REMAP_RST;
			ttype_ff <= `STV_TAGTYPE_RST;
		end else if (wr_go) begin
			case (awaddr_ff)
				`STV_REG_PARSE: pcfg_ff <= merge(pcfg_ff, wdata_ff, wstrb_ff);
				`STV_REG_VLAN: vcfg_ff <= merge(vcfg_ff, wdata_ff, wstrb_ff);
				`STV_REG_REMAP: remap_ff <= merge(remap_ff, wdata_ff, wstrb_ff) & 32'h00FFFFFF;
				`STV_REG_TAGTYPE: ttype_ff <= merge(ttype_ff, wdata_ff, wstrb_ff);
				default: ;
			endcase
		end
	end

	// flow table, all flows disabled after reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int f = 0; f < `STV_NFLOW; f++) begin
				for (int i = 0; i < `STV_NWORD; i++) begin
					flow_ff[f][i] <= 32'h0;
				end
			end
		end else if (wr_go && flow_hit(awaddr_ff, fo_w)) begin
			flow_ff[fo_w[9:6]][fo_w[5:2]] <= merge(flow_ff[fo_w[9:6]][fo_w[5:2]], wdata_ff, wstrb_ff);
		end
	end

	// axi4-lite read side, answer one cycle after the address
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
				`STV_REG_PARSE: s_axi_rdata <= pcfg_ff;
				`STV_REG_VLAN: s_axi_rdata <= vcfg_ff;
				`STV_REG_REMAP: s_axi_rdata <= remap_ff;
				`STV_REG_TAGTYPE: s_axi_rdata <= ttype_ff;
				`STV_REG_STATUS: s_axi_rdata <= {22'h0, state_ff, res_ctrl, res_cat, res_hit, res_index};
				default: begin
					if (flow_hit(s_axi_araddr, fo_r)) begin
						s_axi_rdata <= flow_ff[fo_r[9:6]][fo_r[5:2]];
					end else begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'h2;
					end
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : stv_classifier
`default_nettype wire

// file: stv_classifier_chk.sv
// result and bus handshake checker for the classifier
// bound to every stv_classifier instance; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module stv_classifier_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic        in_eop,
	input wire logic        res_valid,
	input wire logic        res_ready,
	input wire logic        res_hit,
	input wire logic [3:0]  res_index,
	input wire logic [1:0]  res_cat,
	input wire logic        res_ctrl,
	input wire logic        res_xform_ok,
	input wire logic [3:0]  res_vclass,
	input wire logic [2:0]  res_up,
	input wire logic [11:0] res_vid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped early");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped or changed");
	a_eop_result: assert property (in_valid && in_ready && in_eop |=> !in_ready && !res_valid ##1 res_valid)
		else $error("result not ready two edges after frame end");
	a_res_hold: assert property (res_valid && !res_ready |=> res_valid
		&& $stable({res_hit, res_index, res_cat, res_vclass, res_up, res_vid}))
		else $error("held result changed");
	a_res_free: assert property (res_valid && res_ready |=> !res_valid && in_ready)
		else $error("result not released");
	a_miss_index: assert property (res_valid && !res_hit |-> res_index == {1'h0, res_ctrl, res_cat})
		else $error("miss index wrong");
	a_xform_gate: assert property (res_valid |-> res_xform_ok == (res_hit && res_cat == 2'h1))
		else $error("transform flag wrong");
	a_vlan_flags: assert property (res_valid && res_vclass[3:1] != 3'h0
		|-> res_vclass[0] && !(res_vclass[2] && res_vclass[1]))
		else $error("vlan flags inconsistent");
	c_hit: cover property (res_valid && res_hit);
	c_miss: cover property (res_valid && !res_hit);
	c_qinq: cover property (res_valid && res_vclass[3]);
endmodule : stv_classifier_chk
bind stv_classifier stv_classifier_chk i_chk (.clk, .nrst, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .in_valid, .in_ready, .in_eop, .res_valid, .res_ready,
	.res_hit, .res_index, .res_cat, .res_ctrl, .res_xform_ok, .res_vclass, .res_up, .res_vid);
`default_nettype wire

// file: stv_mac_src.sv
// upstream mac byte source for the classifier
// bench fills fr and calls send right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module stv_mac_src (
	input  wire logic       clk,
	input  wire logic       in_ready,
	output logic            in_valid,
	output logic [7:0]      in_data,
	output logic            in_eop,
	output logic            in_ctrl
);
	logic [7:0] fr [40];
	initial begin
		in_valid = 1'h0;
		in_data = 8'h00;
		in_eop = 1'h0;
		in_ctrl = 1'h0;
		foreach (fr[k])
			fr[k] = 8'h00;
	end
	task send(input int n, input logic c);
		for (int k = 0; k < n; k++) begin
			in_valid <= 1'h1;
			in_data <= fr[k]; // wire order, first da byte first
			in_eop <= (k == n - 1);
			in_ctrl <= c; // one control bit per frame
			do @(posedge clk); while (!in_ready);
		end
		in_valid <= 1'h0;
		in_eop <= 1'h0;
		in_data <= ~fr[n - 1];
	endtask : send
endmodule : stv_mac_src
`default_nettype wire

// file: stv_classifier_bench.sv
// self-checking bench for the classifier
// registers over the bus tasks; frames from the mac source model
`timescale 1ns/1ps
`default_nettype none
module stv_classifier_bench
	import stv_pkg::*;
	;
	logic        clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, in_valid, in_ready, in_eop, in_ctrl;
	logic        res_valid, res_ready, res_hit, res_ctrl, res_xform_ok;
	logic [11:0] s_axi_awaddr, s_axi_araddr, res_vid, res_ivid;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb, res_index, res_vclass;
	logic [1:0]  s_axi_bresp, s_axi_rresp, res_cat, rr;
	logic [7:0]  in_data;
	logic [2:0]  res_up, res_iup;
	logic [15:0] res_etype;
	int          num_errors, n_compared;
	logic [63:0] tv [11] = '{64'h0800_0000_0000_0000, 64'h88E5_0000_0000_0001, 64'h88E5_8000_0000_0001,
		64'h88E5_0800_0000_0001, 64'h88E5_0400_0000_0001, 64'h88E5_6000_0000_0001, 64'h88E5_3000_0000_0001,
		64'h88E5_0030_0000_0001, 64'h88E5_002F_0000_0001, 64'h88E5_0000_0000_0000, 64'h88E5_0C00_0000_0001};
	stv_cat_type tc [11] = '{CAT_UNTAGGED, CAT_TAGGED, CAT_BAD, CAT_KAY, CAT_BAD, CAT_BAD, CAT_BAD,
		CAT_BAD, CAT_TAGGED, CAT_BAD, CAT_TAGGED};
	stv_classifier i_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .in_valid, .in_ready, .in_data, .in_eop, .in_ctrl, .res_valid, .res_ready, .res_hit,
		.res_index, .res_cat, .res_ctrl, .res_xform_ok, .res_vclass, .res_up, .res_vid, .res_iup,
		.res_ivid, .res_etype);
	stv_mac_src i_src (.clk, .in_ready, .in_valid, .in_data, .in_eop, .in_ctrl);
	task results;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rd
	function automatic logic [11:0] fa(input int f, input int w);
		return 12'(256 + f * 64 + w * 4);
	endfunction : fa
	task put(input int o, input logic [63:0] v);
		for (int k = 0; k < 8; k++)
			i_src.fr[o + k] = v[63 - 8 * k -: 8];
	endtask : put
	task go(input logic c);
		i_src.send(24, c);
		do @(posedge clk); while (res_valid !== 1'h1);
	endtask : go
	task rel;
		res_ready <= 1'h1;
		@(posedge clk);
		res_ready <= 1'h0;
	endtask : rel
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		results();
	end
	initial begin
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, res_ready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		rd(12'h000); chk("parse cfg", rv, 32'h0000007E);
		rd(12'h004); chk("vlan cfg", rv, 32'h00000038);
		rd(12'h008); chk("remap", rv, 32'h00FAC688);
		rd(12'hFFC); chk("unmapped resp", rr, 2'h2);
		wr(12'hFFC, 32'h0);
		chk("wr unmapped", rr, 2'h2);
		for (int k = 0; k < 11; k++) begin
			put(12, tv[k]);
			put(20, 64'h0);
			go(k[0]);
			chk("cat", res_cat, tc[k]);
			chk("miss index", res_index, {1'h0, k[0], tc[k]});
			chk("ctrl", res_ctrl, k[0]);
			rel();
		end
		wr(12'h000, 32'h0000005E);
		put(12, 64'h88E5_0000_0000_0000);
		go(0); chk("pn check off", res_cat, CAT_TAGGED);
		rel();
		wr(12'h000, 32'h0000007E);
		wr(12'h008, 32'h00E6C688);
		put(12, 64'h88A8_6ABC_8100_C456);
		put(20, 64'h0800_0000_0000_0000);
		go(0); chk("vclass qinq", res_vclass, 4'hD);
		chk("up", res_up, 3'h3);
		chk("vid", res_vid, 12'hABC);
		chk("iup", res_iup, 3'h1);
		chk("ivid", res_ivid, 12'h456);
		chk("etype", res_etype, 16'h0800);
		rel();
		put(12, 64'h8100_A123_88E5_0000);
		put(20, 64'h0000_0001_0000_0000);
		go(1); chk("tag after vlan", res_cat, CAT_UNTAGGED);
		chk("vclass q", res_vclass, 4'h3);
		chk("up q", res_up, 3'h5);
		chk("vid q", res_vid, 12'h123);
		chk("etype q", res_etype, 16'h88E5);
		rel();
		wr(12'h000, 32'h0000007F);
		go(1);
		chk("bypass tag", res_cat, CAT_TAGGED);
		rel();
		wr(12'h004, 32'h00000032);
		go(1); chk("default up", res_up, 3'h2);
		rel();
		wr(12'h004, 32'h00000038);
		wr(fa(1, 4), 32'h5F000000);
		wr(fa(1, 5), 32'h80000000);
		wr(fa(3, 4), 32'h5F000000);
		wr(fa(3, 5), 32'h80000000);
		wr(fa(2, 4), 32'hFF000000);
		put(12, 64'h0800_0000_0000_0000);
		put(20, 64'h0);
		go(0); chk("hit", res_hit, 1'h1);
		chk("tie index", res_index, 4'h1);
		rel();
		wr(fa(1, 3), 32'h00001000);
		wr(fa(1, 4), 32'h5F001234);
		go(0); chk("masked etype", res_index, 4'h3);
		rel();
		wr(fa(3, 4), 32'h50000000);
		go(1); chk("cat disabled", res_index, 4'h4);
		rel();
		wr(fa(1, 4), 32'h5F0088E5);
		rd(fa(1, 4)); chk("flow word", rv, 32'h5F0088E5);
		put(12, 64'h88E5_0000_0000_0001);
		go(0); chk("etype hit", res_index, 4'h1);
		chk("xform", res_xform_ok, 1'h1);
		rel();
		wr(fa(1, 3), 32'h00043000);
		wr(fa(1, 4), 32'h5F0188E5);
		go(0);
		chk("vid needs valid", res_hit, 1'h0);
		rel();
		wr(fa(2, 5), 32'h80000000);
		go(0); chk("prio 15", res_index, 4'h2);
		rel();
		results();
	end
endmodule : stv_classifier_bench
`default_nettype wire
